/* design/core_pkg.sv */
// constants, types and carriers for the core timing, pipeline and alu
package core_pkg;
   localparam int PCLK_PERIOD_NS = 20;
   localparam int PHASES = 4;
   localparam int INSTR_PCLKS = PHASES;
   localparam int INSTR_NS = INSTR_PCLKS * PCLK_PERIOD_NS;
   localparam int REF_IN_HZ = 4_000_000;
   localparam int REF_CYCLE_NS = PHASES * (1_000_000_000 / REF_IN_HZ); // 1000 ns at 4 MHz
   // synchroniser value after reset: master clear pin idles high on its pull-up
   localparam logic [5:0] PIN_SYNC_RST = 6'h08;
   // apb register byte offsets
   localparam logic [11:0] CFG_OFS = 12'h000;
   localparam logic [11:0] PORT_OFS = 12'h004;
   localparam logic [11:0] STAT_OFS = 12'h008;
   localparam logic [11:0] PC_OFS = 12'h00c;
   localparam logic [10:0] CFG_RST = 11'h006; // internal rc, master clear on
   localparam logic [11:0] PORT_RST = 12'hfc0; // all pins input
   localparam logic [11:0] PC_RST = 12'h000;
   // special register addresses in data memory
   localparam logic [4:0] SFR_INDIRECT = 5'h00;
   localparam logic [4:0] SFR_PCL = 5'h02;
   localparam logic [4:0] SFR_STATUS = 5'h03;
   localparam logic [4:0] SFR_FSR = 5'h04;
   localparam logic [4:0] SFR_PORT = 5'h06;
   // status flag positions
   localparam int FLAG_C = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z = 2;
   localparam int MASTER_RESET_N_PIN = 3;
   localparam int XDRV_PIN = 4;
   localparam int XIN_PIN = 5;
   localparam int TMR_PIN = 2;
   localparam logic [11:0] OP_NOP = 12'h000;
   typedef enum logic [3:0] {PH_ONE = 4'h1, PH_TWO = 4'h2, PH_THREE = 4'h4, PH_FOUR = 4'h8} phase_t;
   typedef enum logic [1:0] {
      LOW_POWER_CRYSTAL_MODE = 2'h0, STANDARD_CRYSTAL_MODE = 2'h1, INT_RC_MODE = 2'h2, EXT_RC_MODE = 2'h3
   } osc_mode_t;
   typedef enum logic [4:0] {
      ALU_PASS_F, ALU_PASS_W, ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR, ALU_COM, ALU_INC,
      ALU_DEC, ALU_RR, ALU_RL, ALU_SWAP, ALU_CLR, ALU_BCLR, ALU_BSET
   } alu_op_t;
   typedef struct packed {
      logic [5:0] pullup_en;
      logic wake_en;
      logic timer_pin_sel;
      logic master_reset_n_en;
      osc_mode_t osc_mode;
   } cfg_t;
   typedef struct packed {
      logic [5:0] tris;
      logic [5:0] out;
   } port_t;
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic rd;
      logic we;
   } dmem_req_t;
   typedef struct packed {
      alu_op_t op;
      logic use_lit;
      logic wr_w;
      logic wr_f;
      logic aff_c;
      logic aff_dc;
      logic aff_z;
      logic is_goto;
      logic skip_zero;
      logic skip_clr;
      logic skip_set;
   } dec_t;
   typedef struct packed {
      logic [7:0] res;
      logic c;
      logic dc;
      logic skip;
   } alu_res_t;
endpackage : core_pkg

/* design/cpu_core_pipeline_alu.sv */
// quadrature timing, two-stage pipeline, alu and pin sharing of the core
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module cpu_core_pipeline_alu
   import core_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [11:0] prog_addr,
   input wire logic [11:0] prog_data,
   output dmem_req_t dmem_req,
   input wire logic [7:0] dmem_rdata,
   input wire logic [5:0] pin_in,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe,
   output logic [5:0] pin_pullup,
   output logic crystal_drive_en,
   output logic timer_pin_clock,
   output logic wake_pulse,
   output phase_t phase
);

   phase_t phase_q;
   logic [11:0] pc_q, fetch_addr_q, fetched_q, instruction_latch_q, ir_next;
   logic flush_q;
   logic [7:0] w_q, fsr_q, operand_q, operand_mux, b_opnd;
   logic [2:0] status_q;
   alu_res_t result_q, alu_now;
   dmem_req_t dmem_req_q;
   dec_t dec;
   cfg_t cfg_q;
   port_t port_q;
   logic [5:0] pin_meta_q, pin_sync_q, pin_prev_q;
   logic wake_q, master_reset_n_hold, take_branch;
   logic [4:0] eff_addr;
   logic [31:0] prdata_q, read_mux;
   logic pslverr_q, reg_hit;

   // effective file address, indirect goes through the file select register
   function automatic logic [4:0] file_addr(input logic [11:0] ir, input logic [7:0] fsr);
      file_addr = (ir[4:0] == SFR_INDIRECT) ? fsr[4:0] : ir[4:0];
   endfunction : file_addr

   // addresses held inside the core, never sent to the data memory bus
   function automatic logic is_sfr(input logic [4:0] a);
      is_sfr = (a <= SFR_PORT);
   endfunction : is_sfr

   // eight bit alu, carry out doubles as not-borrow in subtraction
   function automatic alu_res_t alu_calc(input alu_op_t op, input logic [7:0] w, input logic [7:0] b,
                                         input logic [2:0] bsel, input logic c_in);
      logic [8:0] sum;
      logic [4:0] nib;
      alu_res_t r;
      sum = '0;
      nib = '0;
      r = '{res: b, c: c_in, dc: 1'b0, skip: 1'b0};
      case (op)
         ALU_ADD: begin
            sum = {1'b0, b} + {1'b0, w};
            nib = {1'b0, b[3:0]} + {1'b0, w[3:0]};
            r.res = sum[7:0];
            r.c = sum[8];
            r.dc = nib[4];
         end
         ALU_SUB: begin
            sum = {1'b0, b} + {1'b0, ~w} + 9'h001;
            nib = {1'b0, b[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
            r.res = sum[7:0];
            r.c = sum[8]; // low means borrow
            r.dc = nib[4]; // low means nibble borrow
         end
         ALU_AND: r.res = b & w;
         ALU_IOR: r.res = b | w;
         ALU_XOR: r.res = b ^ w;
         ALU_COM: r.res = ~b;
         ALU_INC: r.res = b + 8'h01;
         ALU_DEC: r.res = b - 8'h01;
         ALU_RR: begin
            r.res = {c_in, b[7:1]};
            r.c = b[0];
         end
         ALU_RL: begin
            r.res = {b[6:0], c_in};
            r.c = b[7];
         end
         ALU_SWAP: r.res = {b[3:0], b[7:4]};
         ALU_CLR: r.res = 8'h00;
         ALU_PASS_W: r.res = w;
         ALU_BCLR: r.res = b & ~(8'h01 << bsel);
         ALU_BSET: r.res = b | (8'h01 << bsel);
         default: r.res = b;
      endcase
      alu_calc = r;
   endfunction : alu_calc

   // pin synchronisers, and master clear from the shared input pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_q <= PIN_SYNC_RST; // no false master clear after reset
         pin_sync_q <= PIN_SYNC_RST;
         pin_prev_q <= PIN_SYNC_RST;
      end else begin
         pin_meta_q <= pin_in;
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end
   assign master_reset_n_hold = cfg_q.master_reset_n_en && !pin_sync_q[MASTER_RESET_N_PIN];

   // quadrature phase ring, one pclk per phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q <= PH_ONE;
      end else if (master_reset_n_hold) begin
         phase_q <= PH_ONE;
      end else begin
         unique case (phase_q)
            PH_ONE: phase_q <= PH_TWO;
            PH_TWO: phase_q <= PH_THREE;
            PH_THREE: phase_q <= PH_FOUR;
            PH_FOUR: phase_q <= PH_ONE;
            default: phase_q <= PH_ONE;
         endcase
      end
   end
   assign phase = phase_q;

   // word entering the latch; dropped after a change of flow
   assign ir_next = flush_q ? OP_NOP : fetched_q;
   assign take_branch = dec.is_goto || result_q.skip || (dec.wr_f && eff_addr == SFR_PCL);

   // program counter, fetch address and prefetch, on their own program bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q <= PC_RST;
         fetch_addr_q <= PC_RST;
         fetched_q <= OP_NOP;
         flush_q <= 1'b1;
      end else if (master_reset_n_hold) begin
         pc_q <= PC_RST;
         fetch_addr_q <= PC_RST;
         fetched_q <= OP_NOP;
         flush_q <= 1'b1;
      end else if (phase_q == PH_ONE) begin
         fetch_addr_q <= pc_q; // fetch overlaps execute
         pc_q <= pc_q + 12'h001;
         flush_q <= 1'b0;
      end else if (phase_q == PH_FOUR) begin
         fetched_q <= prog_data; // whole 12-bit word
         if (take_branch) begin
            flush_q <= 1'b1; // extra cycle runs as a no-op
            if (dec.is_goto) begin
               pc_q <= {3'h0, instruction_latch_q[8:0]};
            end else if (!result_q.skip) begin
               pc_q <= {4'h0, result_q.res}; // counter written as a file
            end
         end
      end
   end
   assign prog_addr = fetch_addr_q;

   // instruction latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instruction_latch_q <= OP_NOP;
      end else if (master_reset_n_hold) begin
         instruction_latch_q <= OP_NOP;
      end else if (phase_q == PH_ONE) begin
         instruction_latch_q <= ir_next;
      end
   end

   // decode of the latched instruction
   always_comb begin
      dec = '0;
      dec.op = ALU_PASS_F;
      casez (instruction_latch_q)
         12'b0000_001?_????: begin dec.op = ALU_PASS_W; dec.wr_f = 1'b1; end
         12'b0000_0100_0000: begin dec.op = ALU_CLR; dec.wr_w = 1'b1; dec.aff_z = 1'b1; end
         12'b0000_011?_????: begin dec.op = ALU_CLR; dec.wr_f = 1'b1; dec.aff_z = 1'b1; end
         12'b0000_10??_????: begin dec.op = ALU_SUB; {dec.aff_c, dec.aff_dc, dec.aff_z} = 3'h7; end
         12'b0000_11??_????: begin dec.op = ALU_DEC; dec.aff_z = 1'b1; end
         12'b0001_00??_????: begin dec.op = ALU_IOR; dec.aff_z = 1'b1; end
         12'b0001_01??_????: begin dec.op = ALU_AND; dec.aff_z = 1'b1; end
         12'b0001_10??_????: begin dec.op = ALU_XOR; dec.aff_z = 1'b1; end
         12'b0001_11??_????: begin dec.op = ALU_ADD; {dec.aff_c, dec.aff_dc, dec.aff_z} = 3'h7; end
         12'b0010_00??_????: begin dec.op = ALU_PASS_F; dec.aff_z = 1'b1; end
         12'b0010_01??_????: begin dec.op = ALU_COM; dec.aff_z = 1'b1; end
         12'b0010_10??_????: begin dec.op = ALU_INC; dec.aff_z = 1'b1; end
         12'b0010_11??_????: begin dec.op = ALU_DEC; dec.skip_zero = 1'b1; end
         12'b0011_00??_????: begin dec.op = ALU_RR; dec.aff_c = 1'b1; end
         12'b0011_01??_????: begin dec.op = ALU_RL; dec.aff_c = 1'b1; end
         12'b0011_10??_????: dec.op = ALU_SWAP;
         12'b0011_11??_????: begin dec.op = ALU_INC; dec.skip_zero = 1'b1; end
         12'b0100_????_????: begin dec.op = ALU_BCLR; dec.wr_f = 1'b1; end
         12'b0101_????_????: begin dec.op = ALU_BSET; dec.wr_f = 1'b1; end
         12'b0110_????_????: dec.skip_clr = 1'b1;
         12'b0111_????_????: dec.skip_set = 1'b1;
         12'b101?_????_????: dec.is_goto = 1'b1;
         12'b1100_????_????: begin dec.op = ALU_PASS_F; dec.use_lit = 1'b1; dec.wr_w = 1'b1; end
         12'b1101_????_????: begin dec.op = ALU_IOR; dec.use_lit = 1'b1; dec.wr_w = 1'b1; dec.aff_z = 1'b1; end
         12'b1110_????_????: begin dec.op = ALU_AND; dec.use_lit = 1'b1; dec.wr_w = 1'b1; dec.aff_z = 1'b1; end
         12'b1111_????_????: begin dec.op = ALU_XOR; dec.use_lit = 1'b1; dec.wr_w = 1'b1; dec.aff_z = 1'b1; end
         default: dec.op = ALU_PASS_F;
      endcase
      // byte-oriented group except opcodes 6'h00, 6'h01 and 6'h03: bit five picks file or accumulator
      if (instruction_latch_q[11:10] == 2'b00 && instruction_latch_q[11:6] > 6'h01 &&
          instruction_latch_q[11:6] != 6'h03) begin
         dec.wr_f = instruction_latch_q[5];
         dec.wr_w = !instruction_latch_q[5];
      end
   end
   assign eff_addr = file_addr(instruction_latch_q, fsr_q);

   // operand source: core registers or the data memory bus
   always_comb begin
      unique case (eff_addr)
         SFR_PCL: operand_mux = pc_q[7:0];
         SFR_STATUS: operand_mux = {5'h00, status_q};
         SFR_FSR: operand_mux = fsr_q;
         SFR_PORT: operand_mux = {2'h0, pin_sync_q};
         default: operand_mux = is_sfr(eff_addr) ? 8'h00 : dmem_rdata;
      endcase
      b_opnd = dec.use_lit ? instruction_latch_q[7:0] : operand_mux;
      alu_now = alu_calc(dec.op, w_q, b_opnd, instruction_latch_q[7:5], status_q[FLAG_C]);
      alu_now.skip = (dec.skip_zero && alu_now.res == 8'h00) ||
                     (dec.skip_clr && !b_opnd[instruction_latch_q[7:5]]) ||
                     (dec.skip_set && b_opnd[instruction_latch_q[7:5]]);
   end

   // data memory strobes: read in phase two, write in phase four
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dmem_req_q <= '0;
      end else if (master_reset_n_hold) begin
         dmem_req_q <= '0;
      end else begin
         dmem_req_q.rd <= 1'b0;
         dmem_req_q.we <= 1'b0;
         if (phase_q == PH_ONE) begin
            dmem_req_q.addr <= file_addr(ir_next, fsr_q);
            dmem_req_q.rd <= !is_sfr(file_addr(ir_next, fsr_q));
         end else if (phase_q == PH_THREE) begin
            dmem_req_q.wdata <= alu_now.res;
            dmem_req_q.we <= dec.wr_f && !is_sfr(eff_addr);
         end
      end
   end
   assign dmem_req = dmem_req_q;

   // alu result captured at the end of phase three
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_q <= '0;
         operand_q <= 8'h00;
      end else if (master_reset_n_hold) begin
         result_q <= '0;
         operand_q <= 8'h00;
      end else if (phase_q == PH_THREE) begin
         result_q <= alu_now;
         operand_q <= b_opnd;
      end else if (phase_q == PH_FOUR) begin
         result_q.skip <= 1'b0;
      end
   end

   // accumulator, status and file select written back in phase four
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         w_q <= 8'h00;
         status_q <= 3'h0;
         fsr_q <= 8'h00;
      end else if (master_reset_n_hold) begin
         w_q <= 8'h00;
         status_q <= 3'h0;
         fsr_q <= 8'h00;
      end else if (phase_q == PH_FOUR) begin
         if (dec.wr_w) begin
            w_q <= result_q.res; // unaddressable accumulator
         end
         if (dec.wr_f && eff_addr == SFR_FSR) begin
            fsr_q <= result_q.res;
         end
         if (dec.wr_f && eff_addr == SFR_STATUS) begin
            status_q <= result_q.res[2:0];
         end
         // flags set by the alu override a direct write
         if (dec.aff_c) begin
            status_q[FLAG_C] <= result_q.c;
         end
         if (dec.aff_dc) begin
            status_q[FLAG_DC] <= result_q.dc;
         end
         if (dec.aff_z) begin
            status_q[FLAG_Z] <= (result_q.res == 8'h00);
         end
      end
   end

   // apb read decode
   always_comb begin
      reg_hit = 1'b1;
      unique case (paddr)
         CFG_OFS: read_mux = {21'h0, cfg_q};
         PORT_OFS: read_mux = {20'h0, port_q};
         STAT_OFS: read_mux = {10'h0, pin_sync_q, 5'h00, status_q, w_q};
         PC_OFS: read_mux = {8'h00, fsr_q, 4'h0, pc_q};
         default: begin
            read_mux = 32'h0000_0000;
            reg_hit = 1'b0;
         end
      endcase
   end

   // apb slave: data captured in setup, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (psel && !penable) begin
         prdata_q <= pwrite ? 32'h0000_0000 : read_mux;
         pslverr_q <= !reg_hit;
      end
   end
   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = pslverr_q && psel && penable;

   // configuration and port registers; the core's port write wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= cfg_t'(CFG_RST);
         port_q <= port_t'(PORT_RST);
      end else begin
         if (psel && penable && pwrite && paddr == CFG_OFS) begin
            cfg_q <= cfg_t'(pwdata[10:0]);
         end
         if (psel && penable && pwrite && paddr == PORT_OFS) begin
            port_q <= port_t'(pwdata[11:0]);
         end
         if (!master_reset_n_hold && phase_q == PH_FOUR && dec.wr_f && eff_addr == SFR_PORT) begin
            port_q.out <= result_q.res[5:0];
         end
      end
   end

   // wake on a level change of any port pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= cfg_q.wake_en && (pin_sync_q != pin_prev_q);
      end
   end
   assign wake_pulse = wake_q;

   // pin sharing: master clear, crystal pins and timer input
   always_comb begin
      pin_out = port_q.out;
      pin_oe = ~port_q.tris;
      pin_oe[MASTER_RESET_N_PIN] = 1'b0; // input only
      crystal_drive_en = (cfg_q.osc_mode == LOW_POWER_CRYSTAL_MODE) ||
                         (cfg_q.osc_mode == STANDARD_CRYSTAL_MODE);
      if (crystal_drive_en) begin
         pin_oe[XDRV_PIN] = 1'b0;
      end
      if (cfg_q.osc_mode != INT_RC_MODE) begin
         pin_oe[XIN_PIN] = 1'b0;
      end
      if (cfg_q.timer_pin_sel) begin
         pin_oe[TMR_PIN] = 1'b0;
      end
      pin_pullup = cfg_q.pullup_en;
      pin_pullup[MASTER_RESET_N_PIN] = cfg_q.pullup_en[MASTER_RESET_N_PIN] || cfg_q.master_reset_n_en;
   end
   assign timer_pin_clock = cfg_q.timer_pin_sel && pin_sync_q[TMR_PIN];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_quad;
      ($past(phase_q) == PH_TWO && phase_q == PH_THREE) ##1 phase_q == PH_FOUR;
   endsequence
   sequence s_quiet_cycle;
      !master_reset_n_hold [*3];
   endsequence

   a_phase_ring: assert property ((phase_q == PH_ONE) ##0 s_quiet_cycle |-> s_quad)
      else $error("phase ring out of order");
   a_pc_advance: assert property ((phase_q == PH_ONE && !master_reset_n_hold) |=> pc_q == $past(pc_q) + 12'h001)
      else $error("pc did not advance in phase one");
   a_fetch_capture: assert property ((phase_q == PH_FOUR && !master_reset_n_hold) |=> fetched_q == $past(prog_data))
      else $error("fetched word not captured in phase four");
   a_latch_load: assert property ((phase_q == PH_ONE && !master_reset_n_hold && !flush_q)
                                  |=> instruction_latch_q == $past(fetched_q))
      else $error("instruction latch not loaded");
   a_read_phase: assert property (dmem_req_q.rd |-> phase_q == PH_TWO)
      else $error("data read outside phase two");
   a_write_phase: assert property (dmem_req_q.we |-> phase_q == PH_FOUR)
      else $error("data write outside phase four");
   a_branch_flush: assert property ((phase_q == PH_FOUR && take_branch && !master_reset_n_hold) ##1 !master_reset_n_hold [*2]
                                    |-> instruction_latch_q == OP_NOP)
      else $error("prefetched word not dropped");
   a_sub_borrow: assert property ((phase_q == PH_FOUR && dec.op == ALU_SUB && !master_reset_n_hold)
                                  |=> status_q[FLAG_C] == ($past(operand_q) >= $past(w_q)))
      else $error("borrow flag wrong after subtract");
   a_add_carry: assert property ((phase_q == PH_FOUR && dec.op == ALU_ADD && dec.aff_c && !master_reset_n_hold)
                                 |=> status_q[FLAG_C] == ({1'b0, $past(operand_q)} + {1'b0, $past(w_q)} > 9'h0ff))
      else $error("carry flag wrong after add");
   a_master_reset_n_reset: assert property (master_reset_n_hold |=> phase_q == PH_ONE && pc_q == PC_RST)
      else $error("master clear did not reset the core");
   a_master_reset_n_pullup: assert property (cfg_q.master_reset_n_en |-> pin_pullup[MASTER_RESET_N_PIN])
      else $error("master clear pull-up not forced");
   a_crystal_pin: assert property (crystal_drive_en |-> !pin_oe[XDRV_PIN] && !pin_oe[XIN_PIN])
      else $error("crystal pins driven as port");
endmodule : cpu_core_pipeline_alu

/* bench/core_mem_model.sv */
// program rom and data ram model beside the core
`timescale 1ns/1ns
module core_mem_model
   import core_pkg::*;
(
   input wire logic pclk,
   input wire logic [11:0] prog_addr,
   output logic [11:0] prog_data,
   input wire dmem_req_t dmem_req,
   output logic [7:0] dmem_rdata
);
   logic [11:0] rom [0:4095];
   logic [7:0] ram [0:31];
   // one whole word per fetch address
   assign prog_data = rom[prog_addr];
   // sync ram: data one cycle after rd, churning junk otherwise
   initial dmem_rdata = 8'h5a;
   always @(posedge pclk) begin
      dmem_rdata <= dmem_req.rd ? ram[dmem_req.addr] : ~dmem_rdata;
      if (dmem_req.we) begin
         ram[dmem_req.addr] <= dmem_req.wdata;
      end
   end
endmodule : core_mem_model

/* bench/cpu_core_pipeline_alu_test.sv */
// self-checking bench for the core over apb and its memories
`timescale 1ns/1ns
module cpu_core_pipeline_alu_test;
   import core_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000, prog_addr, prog_data;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0] dmem_rdata;
   logic [5:0] pin_in = 6'h3f, pin_out, pin_oe, pin_pullup;
   logic pready, pslverr, crystal_drive_en, timer_pin_clock, wake_pulse, err;
   dmem_req_t dmem_req;
   phase_t phase;
   logic [3:0] p;
   int failures = 0, comparisons = 0;
   always #10 pclk = ~pclk;
   cpu_core_pipeline_alu u_cpu_core_pipeline_alu (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prog_addr(prog_addr), .prog_data(prog_data), .dmem_req(dmem_req), .dmem_rdata(dmem_rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .crystal_drive_en(crystal_drive_en), .timer_pin_clock(timer_pin_clock), .wake_pulse(wake_pulse),
      .phase(phase));
   core_mem_model u_core_mem_model (.pclk(pclk), .prog_addr(prog_addr), .prog_data(prog_data),
      .dmem_req(dmem_req), .dmem_rdata(dmem_rdata));
   // prints the counts and the verdict, then ends the run
   task automatic report_and_stop();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one apb transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 50) begin
         failures++;
         report_and_stop();
      end
   endtask : apb
   initial begin
      for (int i = 0; i < 4096; i++) u_core_mem_model.rom[i] = OP_NOP;
      // movlw 35, movwf 10, movlw 20, addwf 10 f, subwf 10 w, goto 7, movlw ff, goto 7
      u_core_mem_model.rom[0:7] = '{12'hc35, 12'h030, 12'hc20, 12'h1f0, 12'h090, 12'ha07, 12'hcff, 12'ha07};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      p = phase;
      repeat (8) begin
         @(negedge pclk);
         check({28'h0, phase}, {28'h0, p[2:0], p[3]});
         p = phase;
      end
      $display("test phases done");
      apb(1'b0, CFG_OFS, 32'h0);
      check(rd, {21'h0, CFG_RST});
      apb(1'b0, 12'h010, 32'h0);
      check(rd, 32'h0);
      check({31'h0, err}, 32'h1);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, CFG_OFS, 32'h4 | m);
         check({30'h0, pin_pullup[3], crystal_drive_en}, {30'h0, 1'b1, m < 2});
      end
      $display("test pins done");
      repeat (60) @(posedge pclk);
      apb(1'b0, STAT_OFS, 32'h0);
      check({21'h0, rd[10:0]}, {21'h0, 3'b011, 8'h35});
      check({24'h0, u_core_mem_model.ram[5'h10]}, 32'h55);
      $display("test program done");
      report_and_stop();
   end
endmodule : cpu_core_pipeline_alu_test
